// ---- src/bfm_pkg.sv ----
// Purpose: shared constants and types for the bcd fixup / minus-one slice
// Assumes: 8-bit core, one instruction per issue strobe
// Notes: opcode encodings match the core decoder
package bfm_pkg;
  localparam logic [7:0] OPC_BCD_FIX = 8'hD4;
  localparam logic [7:0] OPC_DEC_ACC = 8'h14;
  localparam logic [7:0] OPC_DEC_DIR = 8'h15;
  localparam logic [6:0] OPC_DEC_IND = 7'h0B;
  localparam logic [4:0] OPC_DEC_BANK = 5'h03;
  localparam logic [3:0] NIB_LIMIT = 4'h9;
  localparam logic [3:0] NIB_FIX = 4'h6;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam int NUM_BANK = 8;
  localparam logic [2:0] BANK_SEL_LSB = 3'h0;

  typedef struct packed {
    logic cy;
    logic half_carry_flag;
    logic signed_range_flag;
  } bfm_flags_t;

  typedef enum logic [1:0] {
    BFM_SRC_ACC = 2'b00,
    BFM_SRC_BANK = 2'b01,
    BFM_SRC_DIR = 2'b11,
    BFM_SRC_IND = 2'b10
  } bfm_src_t;

  typedef enum logic [1:0] {
    BFM_IDLE = 2'b00,
    BFM_MEM_WB = 2'b01
  } bfm_state_t;
endpackage

// ---- src/bfm_bank_mem.sv ----
// Purpose: eight-entry bank register store with registered read
// Assumes: one write port, one read port
// Notes: read data appear one cycle after the address
`timescale 1ns/1ns
module bfm_bank_mem (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_raddr,
  output logic [7:0] o_rdata,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [7:0] i_wdata
);
  logic [7:0] mem_r [bfm_pkg::NUM_BANK];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = mem_r[i_raddr];
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  genvar g;
  for (g = 0; g < bfm_pkg::NUM_BANK; g++) begin : g_ent
    always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
        mem_r[g] <= 8'h00;
      end else if (i_we && i_waddr == 3'(g)) begin
        mem_r[g] <= i_wdata;
      end
    end
  end

  assign o_rdata = rdata_r;
endmodule

// ---- src/bfm_core.sv ----
// Purpose: bcd correction of the accumulator and subtract-one on four operand kinds
// Assumes: decoder pulses i_issue with the opcode; memory bytes arrive on i_mem_*
// Notes: bank registers live here; direct/indirect bytes go out over a mem port
// Functional notes
// RULE1: bcd fix adds six per nibble when above nine or nibble carry set
// RULE2: bcd fix only sets carry on nibble overflow, never clears it, signed flag untouched
// RULE3: subtract-one lowers operand by one, 00H wraps to 0FFH
// RULE4: subtract-one leaves every status flag unchanged
// RULE5: accumulator, bank, direct and indirect sources; bank index from opcode low bits
// RULE6: port targets read and rewrite the output latch, not the pins
// RULE7: accumulator, bank and bcd forms finish in one instruction cycle
`timescale 1ns/1ns
module bfm_core (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_issue,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_operand_addr,
  input wire bfm_pkg::bfm_flags_t i_flags,
  input wire logic i_acc_load,
  input wire logic [7:0] i_acc_data,
  input wire logic [7:0] i_mem_latch_data,
  input wire logic [7:0] i_mem_pin_data,
  input wire logic i_mem_is_port,
  output logic [7:0] o_mem_addr,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  output logic [7:0] o_acc,
  output bfm_pkg::bfm_flags_t o_flags,
  output logic o_flags_we,
  output logic o_busy,
  output logic o_done
);
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  bfm_pkg::bfm_flags_t flags_r;
  bfm_pkg::bfm_flags_t flags_nxt;
  logic flags_we_r;
  logic flags_we_nxt;
  bfm_pkg::bfm_state_t state_r;
  bfm_pkg::bfm_state_t state_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic [7:0] mwdata_r;
  logic [7:0] mwdata_nxt;
  logic mwe_r;
  logic mwe_nxt;
  logic done_r;
  logic done_nxt;
  logic [2:0] bank_sel_r;
  logic [2:0] bank_sel_nxt;
  logic bank_pend_r;
  logic bank_pend_nxt;
  logic bank_we;
  logic [7:0] bank_rdata;
  logic [7:0] mem_byte;
  logic [2:0] bank_raddr;
  logic is_bcd;
  logic is_dec_acc;
  logic is_dec_bank;
  logic is_dec_dir;
  logic is_dec_ind;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [3:0] hi_in;
  logic lo_fix;
  logic hi_fix;
  logic carry_seen;
  logic [7:0] bcd_res;

  assign is_bcd = i_issue && i_opcode == bfm_pkg::OPC_BCD_FIX;
  assign is_dec_acc = i_issue && i_opcode == bfm_pkg::OPC_DEC_ACC;
  assign is_dec_dir = i_issue && i_opcode == bfm_pkg::OPC_DEC_DIR;
  assign is_dec_ind = i_issue && i_opcode[7:1] == bfm_pkg::OPC_DEC_IND;
  assign is_dec_bank = i_issue && i_opcode[7:3] == bfm_pkg::OPC_DEC_BANK; // see RULE5
  assign bank_raddr = i_opcode[2:0];

  // bank read is registered, so the write back happens one cycle later
  bfm_bank_mem u_bank (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_raddr(bank_raddr),
    .o_rdata(bank_rdata),
    .i_we(bank_we),
    .i_waddr(bank_sel_r),
    .i_wdata(bank_rdata - bfm_pkg::BYTE_ONE)
  );
  assign bank_we = bank_pend_r; // see RULE3

  // two-step nibble correction; high step sees the low step's carry
  always_comb begin
    lo_fix = (acc_r[3:0] > bfm_pkg::NIB_LIMIT) || i_flags.half_carry_flag; // see RULE1
    lo_sum = {1'b0, acc_r[3:0]} + (lo_fix ? {1'b0, bfm_pkg::NIB_FIX} : 5'h00);
    hi_in = acc_r[7:4] + {3'h0, lo_sum[4]};
    carry_seen = i_flags.cy || (lo_sum[4] && acc_r[7:4] == 4'hF);
    hi_fix = (hi_in > bfm_pkg::NIB_LIMIT) || carry_seen; // see RULE1
    hi_sum = {1'b0, hi_in} + (hi_fix ? {1'b0, bfm_pkg::NIB_FIX} : 5'h00);
    bcd_res = {hi_sum[3:0], lo_sum[3:0]};
  end

  // port operands use the output latch so pin loading cannot corrupt the result
  assign mem_byte = i_mem_is_port ? i_mem_latch_data : i_mem_pin_data; // see RULE6

  always_comb begin
    acc_nxt = acc_r;
    flags_nxt = i_flags;
    flags_we_nxt = 1'b0;
    state_nxt = state_r;
    addr_nxt = addr_r;
    mwdata_nxt = mwdata_r;
    mwe_nxt = 1'b0;
    done_nxt = 1'b0;
    bank_sel_nxt = bank_sel_r;
    bank_pend_nxt = 1'b0;
    case (state_r)
      bfm_pkg::BFM_IDLE: begin
        if (i_acc_load) begin
          acc_nxt = i_acc_data;
        end
        if (is_bcd) begin
          acc_nxt = bcd_res; // see RULE7
          flags_nxt.cy = carry_seen || hi_sum[4]; // see RULE2
          flags_nxt.signed_range_flag = i_flags.signed_range_flag; // see RULE2
          flags_we_nxt = 1'b1;
          done_nxt = 1'b1;
        end else if (is_dec_acc) begin
          acc_nxt = acc_r - bfm_pkg::BYTE_ONE; // see RULE3
          done_nxt = 1'b1; // see RULE7
        end else if (is_dec_bank) begin
          bank_sel_nxt = bank_raddr;
          bank_pend_nxt = 1'b1;
          done_nxt = 1'b1; // see RULE7
        end else if (is_dec_dir || is_dec_ind) begin
          addr_nxt = i_operand_addr;
          state_nxt = bfm_pkg::BFM_MEM_WB;
        end
      end
      bfm_pkg::BFM_MEM_WB: begin
        mwdata_nxt = mem_byte - bfm_pkg::BYTE_ONE; // see RULE3
        mwe_nxt = 1'b1; // see RULE6
        done_nxt = 1'b1;
        state_nxt = bfm_pkg::BFM_IDLE;
      end
      default: begin
        state_nxt = bfm_pkg::BFM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      acc_r <= bfm_pkg::ACC_RST;
      flags_r <= '0;
      flags_we_r <= 1'b0;
      state_r <= bfm_pkg::BFM_IDLE;
      addr_r <= 8'h00;
      mwdata_r <= 8'h00;
      mwe_r <= 1'b0;
      done_r <= 1'b0;
      bank_sel_r <= bfm_pkg::BANK_SEL_LSB;
      bank_pend_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      flags_we_r <= flags_we_nxt;
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      mwdata_r <= mwdata_nxt;
      mwe_r <= mwe_nxt;
      done_r <= done_nxt;
      bank_sel_r <= bank_sel_nxt;
      bank_pend_r <= bank_pend_nxt;
    end
  end

  assign o_acc = acc_r;
  assign o_flags = flags_r;
  assign o_flags_we = flags_we_r; // flags only written by the bcd fix, see RULE4
  assign o_mem_addr = addr_r;
  assign o_mem_we = mwe_r;
  assign o_mem_wdata = mwdata_r;
  assign o_busy = state_r != bfm_pkg::BFM_IDLE;
  assign o_done = done_r;

  a_dec_acc_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE3
    is_dec_acc && state_r == bfm_pkg::BFM_IDLE |=> acc_r == $past(acc_r) - 8'h01)
    else $error("acc decrement wrong");
  a_dec_no_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE4
    !$past(is_bcd) |-> !o_flags_we)
    else $error("flags written by non bcd op");
  a_bcd_carry_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE2
    is_bcd && i_flags.cy && state_r == bfm_pkg::BFM_IDLE |=> o_flags.cy && o_flags_we)
    else $error("bcd fix cleared carry");
  a_bcd_ov_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE2
    is_bcd && state_r == bfm_pkg::BFM_IDLE
    |=> o_flags.signed_range_flag == $past(i_flags.signed_range_flag))
    else $error("bcd fix touched signed flag");
  a_bcd_low_fix: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE1
    is_bcd && state_r == bfm_pkg::BFM_IDLE && !i_flags.half_carry_flag && acc_r[3:0] <= 4'h9
    |=> acc_r[3:0] == $past(acc_r[3:0]))
    else $error("low nibble changed without cause");
  a_bcd_one_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE7
    (is_bcd || is_dec_acc || is_dec_bank) && state_r == bfm_pkg::BFM_IDLE |=> o_done)
    else $error("single cycle op not done");
  a_bank_wb: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE5
    is_dec_bank && state_r == bfm_pkg::BFM_IDLE |=> bank_we && bank_sel_r == $past(i_opcode[2:0]))
    else $error("bank index wrong");
  a_port_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE6
    state_r == bfm_pkg::BFM_MEM_WB && i_mem_is_port
    |=> o_mem_we && o_mem_wdata == $past(i_mem_latch_data) - 8'h01)
    else $error("port decrement not from latch");
  a_dec_mem_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE3
    state_r == bfm_pkg::BFM_MEM_WB && !i_mem_is_port
    |=> o_mem_we && o_mem_wdata == $past(i_mem_pin_data) - bfm_pkg::BYTE_ONE)
    else $error("memory decrement wrong");
  a_bcd_carry_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE2
    is_bcd && state_r == bfm_pkg::BFM_IDLE && acc_r[7:4] > bfm_pkg::NIB_LIMIT |=> o_flags.cy)
    else $error("bcd fix missed high carry");
  a_bcd_no_adjust: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RULE1
    is_bcd && state_r == bfm_pkg::BFM_IDLE && !i_flags.cy && !i_flags.half_carry_flag
    && acc_r[7:4] <= bfm_pkg::NIB_LIMIT && acc_r[3:0] <= bfm_pkg::NIB_LIMIT
    |=> acc_r == $past(acc_r) && !o_flags.cy)
    else $error("valid bcd value altered");
endmodule

// ---- verification/tb_bcd_fixup_and_minus_one.sv ----
// Purpose: self-checking bench for bfm_core
// Assumes: ops issued one at a time, done pulses checked in issue order
// Notes: bank results are internal, so only their timing and flags are seen
`timescale 1ns/1ns
module tb_bcd_fixup_and_minus_one;
  typedef struct {int kind; logic [7:0] val; logic cy; logic ov; logic [7:0] adr;} bfm_exp_t;
  logic ref_clk = 0, rst_b = 0, issue = 0, acc_load = 0, is_port = 0;
  logic [7:0] opcode = 8'h00, adr = 8'h00, acc_data = 8'h00, latch = 8'h00, pin = 8'h00;
  bfm_pkg::bfm_flags_t flags = '0, o_flags;
  logic [7:0] o_mem_addr, o_mem_wdata, o_acc, acc_m;
  logic o_mem_we, o_flags_we, o_busy, o_done;
  int err_count = 0, checks = 0, seed = 61;
  bfm_exp_t q[$];
  bfm_core dut_u (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_issue(issue), .i_opcode(opcode),
    .i_operand_addr(adr), .i_flags(flags), .i_acc_load(acc_load), .i_acc_data(acc_data),
    .i_mem_latch_data(latch), .i_mem_pin_data(pin), .i_mem_is_port(is_port),
    .o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc),
    .o_flags(o_flags), .o_flags_we(o_flags_we), .o_busy(o_busy), .o_done(o_done));
  always #25 ref_clk = ~ref_clk;
  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    cmp_byte(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_op(input logic [7:0] opc, input logic [7:0] a, input bfm_exp_t e);
    q.push_back(e);
    @(posedge ref_clk); #2;
    issue = 1; opcode = opc; adr = a;
    @(posedge ref_clk); #2;
    issue = 0;
    @(negedge ref_clk);
    if (e.kind == 2) cmp_bit("busy", 1'b1, o_busy);
    else cmp_bit("done", 1'b1, o_done);
    @(posedge ref_clk); #2;
  endtask
  task automatic load(input logic [7:0] v);
    @(posedge ref_clk); #2;
    acc_load = 1; acc_data = v;
    @(posedge ref_clk); #2;
    acc_load = 0; acc_m = v;
  endtask
  function automatic bfm_exp_t bcd_exp(input logic [7:0] a, input bfm_pkg::bfm_flags_t f);
    logic [8:0] s;
    bfm_exp_t e;
    e = '{0, a, f.cy, f.signed_range_flag, 8'h00};
    if (e.val[3:0] > 4'h9 || f.half_carry_flag) begin
      s = {1'b0, e.val} + 9'h006; e.val = s[7:0]; e.cy = e.cy | s[8];
    end
    if (e.val[7:4] > 4'h9 || e.cy) begin
      s = {1'b0, e.val} + 9'h060; e.val = s[7:0]; e.cy = e.cy | s[8];
    end
    return e;
  endfunction
  always @(negedge ref_clk) if (rst_b && o_done === 1'b1) begin
    bfm_exp_t e;
    if (q.size() == 0) begin
      err_count++;
      $display("CHECK FAILED done expected none seen 1");
    end else begin
      e = q.pop_front();
      if (e.kind == 0) begin
        cmp_byte("bcd acc", e.val, o_acc);
        cmp_bit("bcd carry", e.cy, o_flags.cy);
        cmp_bit("bcd signed", e.ov, o_flags.signed_range_flag);
        cmp_bit("bcd flags_we", 1'b1, o_flags_we);
      end else if (e.kind == 2) begin
        cmp_bit("mem we", 1'b1, o_mem_we);
        cmp_byte("mem addr", e.adr, o_mem_addr);
        cmp_byte("mem wdata", e.val, o_mem_wdata);
      end else begin
        if (e.kind == 1) cmp_byte("dec acc", e.val, o_acc);
        cmp_bit("dec flags_we", 1'b0, o_flags_we);
        cmp_bit("dec carry", e.cy, o_flags.cy);
        cmp_bit("dec signed", e.ov, o_flags.signed_range_flag);
      end
    end
  end
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    bfm_exp_t e;
    repeat (16) @(posedge ref_clk);
    #2 rst_b = 1;
    @(negedge ref_clk);
    cmp_byte("reset acc", 8'h00, o_acc);
    cmp_bit("reset busy", 1'b0, o_busy);
    // boundary nibbles first, then random
    for (int i = 0; i < 14; i++) begin
      load(i == 0 ? 8'h9A : i == 1 ? 8'h99 : i == 2 ? 8'hA9 : 8'($random(seed)));
      flags = i < 3 ? 3'b000 : 3'($random(seed));
      e = bcd_exp(acc_m, flags);
      do_op(bfm_pkg::OPC_BCD_FIX, 8'h00, e);
    end
    $display("test bcd fix done");
    load(8'h00);
    for (int i = 0; i < 6; i++) begin
      flags = 3'($random(seed));
      acc_m = acc_m - 8'h01;
      do_op(bfm_pkg::OPC_DEC_ACC, 8'h00, '{1, acc_m, flags.cy, flags.signed_range_flag, 8'h00});
    end
    $display("test dec acc done");
    for (int i = 0; i < 8; i++) begin
      flags = 3'($random(seed));
      do_op({5'h03, 3'(i)}, 8'h00, '{3, 8'h00, flags.cy, flags.signed_range_flag, 8'h00});
    end
    $display("test dec bank done");
    // on port ops the pins are set to the latch inverse so a wrong source shows up
    for (int i = 0; i < 8; i++) begin
      is_port = i[0];
      latch = i < 2 ? 8'h00 : 8'($random(seed));
      pin = i < 2 ? 8'h00 : 8'($random(seed));
      if (is_port) pin = ~latch;
      e = '{2, (is_port ? latch : pin) - 8'h01, 1'b0, 1'b0, 8'($random(seed))};
      do_op(i < 4 ? bfm_pkg::OPC_DEC_DIR : {7'h0B, i[0]}, e.adr, e);
    end
    $display("test dec memory done");
    repeat (4) @(posedge ref_clk);
    cmp_bit("queue empty", 1'b1, q.size() == 0);
    test_done();
  end
endmodule
